// ==== asm_pkg.sv ====
// Constants, field layouts and carrier types for the amplifier status monitor.
// Assumes a byte-wide register port inside the device, one clock, one reset.
package asm_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ASM_ADDR_RDIFF_MAG = 8'h6f;
  localparam logic [7:0] ASM_ADDR_ROFFSET = 8'h71;
  localparam logic [7:0] ASM_ADDR_MUTE = 8'h72;
  localparam logic [7:0] ASM_ADDR_RATE = 8'h73;
  localparam logic [7:0] ASM_ADDR_BOOTPWR = 8'h76;
  localparam logic [7:0] ASM_ADDR_PINS = 8'h77;

  // ==========================================================
  // Field positions
  localparam int ASM_SIGN_BIT = 7;
  localparam int ASM_BOOT_BIT = 7;
  localparam int ASM_GP2_BIT = 5;
  localparam int ASM_MUTE_BIT = 4;
  localparam int ASM_GP0_BIT = 3;
  localparam int ASM_FIELD_LSB = 0;
  localparam int ASM_CODE_MSB = 4;
  localparam int ASM_MUTE_MSB = 1;
  localparam int ASM_RATE_MSB = 2;
  localparam int ASM_PWR_MSB = 3;

  // ==========================================================
  // Reserved read/write masks and reset values
  localparam logic [7:0] ASM_RSV_ROFFSET_MASK = 8'h60;
  localparam logic [7:0] ASM_RSV_MUTE_MASK = 8'hfc;
  localparam logic [7:0] ASM_RSV_RATE_MASK = 8'hf8;
  localparam logic [7:0] ASM_RSV_BOOTPWR_MASK = 8'h70;
  localparam logic [7:0] ASM_RSV_PINS_MASK = 8'hc0;
  localparam logic [7:0] ASM_RSV_RESET = 8'h00;
  localparam logic [7:0] ASM_UNMAPPED_DATA = 8'h00;

  // ==========================================================
  // Mute decoder codes
  localparam logic [1:0] ASM_MUTE_HIGH = 2'h3;
  localparam logic [1:0] ASM_MUTE_MID = 2'h1;
  localparam logic [1:0] ASM_MUTE_LOW = 2'h0;

  // ==========================================================
  // Boot flag polarity, power state reset and rate mode reset
  localparam logic ASM_BOOT_DONE = 1'b1;
  localparam logic ASM_BOOT_BUSY = 1'b0;
  localparam logic [3:0] ASM_PWR_POWERDOWN = 4'h0;
  localparam logic [2:0] ASM_RATE_RESET = 3'h0;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic rightDiffOffsetSign;
    logic [7:0] rightDiffOffsetMagnitude;
    logic [4:0] rightCommonFbOffsetCode;
    logic muteAboveHigh;
    logic muteAboveLow;
    logic autoConfigActive;
    logic [2:0] autoRateMode;
    logic [2:0] swRateMode;
    logic bootDone;
    logic [3:0] outputPowerState;
    logic gpPin2Level;
    logic threeLevelMutePin;
    logic gpPin0Level;
  } asm_status_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wrEn;
    logic rdEn;
    logic [7:0] wrData;
  } asm_reg_req_t;

  typedef struct packed {
    logic rightDiffOffsetSign;
    logic [7:0] rightDiffOffsetMagnitude;
    logic [4:0] rightCommonFbOffsetCode;
    logic [1:0] muteDecodeState;
    logic [2:0] rateModeMonitor;
    logic bootDone;
    logic [3:0] outputPowerState;
    logic gpPin2Level;
    logic threeLevelMutePin;
    logic gpPin0Level;
    logic [7:0] rsvOffset;
    logic [7:0] rsvMute;
    logic [7:0] rsvRate;
    logic [7:0] rsvBootPwr;
    logic [7:0] rsvPins;
    logic [7:0] rdData;
    logic rdValid;
  } asm_state_t;

endpackage

// ==== asm_status_monitor_assertions.sv ====
// Concurrent checks on the ports of the status register group.
// Assumes it is bound into asm_status_monitor_regs; one clock, async low reset.
`timescale 1ns/10ps
// ==========================================================
// Checker
module asm_status_monitor_assertions (
  input wire logic sysClk,
  input wire logic rstn,
  input wire asm_pkg::asm_reg_req_t regReq,
  input wire asm_pkg::asm_status_t statusIn,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (!rstn);
  logic r1, r2;
  logic [7:0] a1;
  asm_pkg::asm_status_t s1, s2;
  // A read answers with status from the edge before it was taken
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      {r1, r2, a1, s1, s2} <= '0;
    end else begin
      {r1, r2, a1, s1, s2} <= {1'b1, r1, regReq.addr, statusIn, s1};
    end
  end
  // Answers in the first two cycles after reset are skipped, their snapshot timing differs
  wire logic hit = regRdValid && r2;
  chk_sign_bit: assert property (hit && a1 == 8'h71 |-> regRdData[7] == s2.rightDiffOffsetSign)
    else $error("offset sign wrong");
  chk_feedback_code: assert property (hit && a1 == 8'h71 |->
    regRdData[4:0] == s2.rightCommonFbOffsetCode)
    else $error("feedback code wrong");
  chk_diff_mag: assert property (hit && a1 == 8'h6f |-> regRdData == s2.rightDiffOffsetMagnitude)
    else $error("magnitude wrong");
  chk_mute_code: assert property (hit && a1 == 8'h72 |->
    regRdData[1:0] == (s2.muteAboveHigh ? 2'h3 : {1'b0, s2.muteAboveLow}))
    else $error("mute code wrong");
  chk_rate_select: assert property (hit && a1 == 8'h73 |->
    regRdData[2:0] == (s2.autoConfigActive ? s2.autoRateMode : s2.swRateMode))
    else $error("rate mode wrong");
  chk_boot_flag: assert property (hit && a1 == 8'h76 |-> regRdData[7] == s2.bootDone)
    else $error("boot flag wrong");
  chk_power_state: assert property (hit && a1 == 8'h76 |-> regRdData[3:0] == s2.outputPowerState)
    else $error("power state wrong");
  chk_pin_levels: assert property (hit && a1 == 8'h77 |->
    regRdData[5:0] == {s2.gpPin2Level, s2.threeLevelMutePin, s2.gpPin0Level, 3'h0})
    else $error("pin levels wrong");
endmodule
bind asm_status_monitor_regs asm_status_monitor_assertions chk (.sysClk(sysClk), .rstn(rstn),
  .regReq(regReq), .statusIn(statusIn), .regRdData(regRdData), .regRdValid(regRdValid));

// ==== asm_status_monitor_regs.sv ====
// Status register group of the amplifier, read-only but for reserved bits: offset calibration,
// mute decode, rate mode, boot/power state and raw pin levels.
// Assumes status inputs and register port are synchronous to sys_clk.
`timescale 1ns/10ps

module asm_status_monitor_regs (
  input wire logic sysClk,
  input wire logic rstn,
  input wire asm_pkg::asm_reg_req_t regReq,
  input wire asm_pkg::asm_status_t statusIn,
  output logic [7:0] regRdData,
  output logic regRdValid
);

  // ==========================================================
  // Helpers
  // Only reserved bits take a write; monitor bits keep their status
  function automatic logic [7:0] rsvWrite(input logic [7:0] old, input logic [7:0] data,
                                          input logic [7:0] mask);
    rsvWrite = (old & ~mask) | (data & mask);
  endfunction

  function automatic logic [1:0] muteDecode(input logic aboveHigh, input logic aboveLow);
    if (aboveHigh) begin
      muteDecode = asm_pkg::ASM_MUTE_HIGH;
    end else if (aboveLow) begin
      muteDecode = asm_pkg::ASM_MUTE_MID;
    end else begin
      muteDecode = asm_pkg::ASM_MUTE_LOW;
    end
  endfunction

  // ==========================================================
  // State
  asm_pkg::asm_state_t state;
  asm_pkg::asm_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.rdValid = 1'b0;

    // Status is sampled each cycle so a read sees a coherent snapshot
    next_state.rightDiffOffsetSign = statusIn.rightDiffOffsetSign;
    next_state.rightDiffOffsetMagnitude = statusIn.rightDiffOffsetMagnitude;
    next_state.rightCommonFbOffsetCode = statusIn.rightCommonFbOffsetCode;
    next_state.muteDecodeState = muteDecode(statusIn.muteAboveHigh,
                                            statusIn.muteAboveLow);
    // Codes pass untouched; the meaning depends on the mode in use
    if (statusIn.autoConfigActive) begin
      next_state.rateModeMonitor = statusIn.autoRateMode;
    end else begin
      next_state.rateModeMonitor = statusIn.swRateMode;
    end
    next_state.bootDone = statusIn.bootDone ? asm_pkg::ASM_BOOT_DONE
                                            : asm_pkg::ASM_BOOT_BUSY;
    next_state.outputPowerState = statusIn.outputPowerState;
    next_state.gpPin2Level = statusIn.gpPin2Level;
    next_state.threeLevelMutePin = statusIn.threeLevelMutePin;
    next_state.gpPin0Level = statusIn.gpPin0Level;

    // ==========================================================
    // Writes
    if (regReq.wrEn) begin
      case (regReq.addr)
        asm_pkg::ASM_ADDR_ROFFSET: begin
          next_state.rsvOffset = rsvWrite(state.rsvOffset, regReq.wrData,
                                          asm_pkg::ASM_RSV_ROFFSET_MASK);
        end
        asm_pkg::ASM_ADDR_MUTE: begin
          next_state.rsvMute = rsvWrite(state.rsvMute, regReq.wrData,
                                        asm_pkg::ASM_RSV_MUTE_MASK);
        end
        asm_pkg::ASM_ADDR_RATE: begin
          next_state.rsvRate = rsvWrite(state.rsvRate, regReq.wrData,
                                        asm_pkg::ASM_RSV_RATE_MASK);
        end
        asm_pkg::ASM_ADDR_BOOTPWR: begin
          next_state.rsvBootPwr = rsvWrite(state.rsvBootPwr, regReq.wrData,
                                           asm_pkg::ASM_RSV_BOOTPWR_MASK);
        end
        asm_pkg::ASM_ADDR_PINS: begin
          next_state.rsvPins = rsvWrite(state.rsvPins, regReq.wrData,
                                        asm_pkg::ASM_RSV_PINS_MASK);
        end
        default: begin
          // Magnitude register and unmapped offsets take no write
        end
      endcase
    end

    // ==========================================================
    // Reads, one cycle latency from the registered snapshot
    if (regReq.rdEn) begin
      next_state.rdValid = 1'b1;
      next_state.rdData = asm_pkg::ASM_UNMAPPED_DATA;
      case (regReq.addr)
        asm_pkg::ASM_ADDR_RDIFF_MAG: begin
          next_state.rdData = state.rightDiffOffsetMagnitude;
        end
        asm_pkg::ASM_ADDR_ROFFSET: begin
          next_state.rdData = state.rsvOffset;
          next_state.rdData[asm_pkg::ASM_SIGN_BIT] = state.rightDiffOffsetSign;
          next_state.rdData[asm_pkg::ASM_CODE_MSB:asm_pkg::ASM_FIELD_LSB] =
            state.rightCommonFbOffsetCode;
        end
        asm_pkg::ASM_ADDR_MUTE: begin
          next_state.rdData = state.rsvMute;
          next_state.rdData[asm_pkg::ASM_MUTE_MSB:asm_pkg::ASM_FIELD_LSB] =
            state.muteDecodeState;
        end
        asm_pkg::ASM_ADDR_RATE: begin
          next_state.rdData = state.rsvRate;
          next_state.rdData[asm_pkg::ASM_RATE_MSB:asm_pkg::ASM_FIELD_LSB] =
            state.rateModeMonitor;
        end
        asm_pkg::ASM_ADDR_BOOTPWR: begin
          next_state.rdData = state.rsvBootPwr;
          next_state.rdData[asm_pkg::ASM_BOOT_BIT] = state.bootDone;
          next_state.rdData[asm_pkg::ASM_PWR_MSB:asm_pkg::ASM_FIELD_LSB] =
            state.outputPowerState;
        end
        asm_pkg::ASM_ADDR_PINS: begin
          // Unused low pins read zero
          next_state.rdData = state.rsvPins;
          next_state.rdData[asm_pkg::ASM_GP2_BIT] = state.gpPin2Level;
          next_state.rdData[asm_pkg::ASM_MUTE_BIT] = state.threeLevelMutePin;
          next_state.rdData[asm_pkg::ASM_GP0_BIT] = state.gpPin0Level;
        end
        default: begin
          next_state.rdData = asm_pkg::ASM_UNMAPPED_DATA;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      state.rightDiffOffsetSign <= '0;
      state.rightDiffOffsetMagnitude <= '0;
      state.rightCommonFbOffsetCode <= '0;
      state.muteDecodeState <= asm_pkg::ASM_MUTE_LOW;
      state.rateModeMonitor <= asm_pkg::ASM_RATE_RESET;
      state.bootDone <= asm_pkg::ASM_BOOT_BUSY;
      state.outputPowerState <= asm_pkg::ASM_PWR_POWERDOWN;
      state.gpPin2Level <= '0;
      state.threeLevelMutePin <= '0;
      state.gpPin0Level <= '0;
      state.rsvOffset <= asm_pkg::ASM_RSV_RESET;
      state.rsvMute <= asm_pkg::ASM_RSV_RESET;
      state.rsvRate <= asm_pkg::ASM_RSV_RESET;
      state.rsvBootPwr <= asm_pkg::ASM_RSV_RESET;
      state.rsvPins <= asm_pkg::ASM_RSV_RESET;
      state.rdData <= asm_pkg::ASM_UNMAPPED_DATA;
      state.rdValid <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign regRdData = state.rdData;
  assign regRdValid = state.rdValid;

endmodule

// ==== asm_tb.sv ====
// Self-checking bench for the status register group.
// Assumes the package is compiled first and the checker binds itself.
`timescale 1ns/10ps
module tb;
  logic sysClk, rstn, regRdValid;
  asm_pkg::asm_reg_req_t req;
  asm_pkg::asm_status_t st;
  logic [7:0] regRdData;
  int nMismatch, totalChecks, cycles;
  // ==========================================================
  // Device and clock
  asm_status_monitor_regs uut (.sysClk(sysClk), .rstn(rstn), .regReq(req), .statusIn(st),
    .regRdData(regRdData), .regRdValid(regRdValid));
  initial begin
    sysClk = 1'b0;
    forever #10 sysClk = ~sysClk;
  end
  // Run needs some 200 cycles
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nMismatch++;
      giveVerdict();
    end
  end
  // ==========================================================
  // Port tasks
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    totalChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sysClk);
    req <= '{addr: a, wrEn: 1'b1, rdEn: 1'b0, wrData: d};
    @(posedge sysClk);
    req.wrEn <= 1'b0;
  endtask
  // Answer is sampled mid-cycle, clear of the launching edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sysClk);
    req.addr <= a;
    req.rdEn <= 1'b1;
    @(posedge sysClk);
    req.rdEn <= 1'b0;
    @(negedge sysClk);
    check({7'h00, regRdValid}, 8'h01);
    check(regRdData, e);
  endtask
  // ==========================================================
  // Scenarios
  task automatic testReset;
    for (int a = 8'h71; a < 8'h78; a++) begin
      rd(8'(a), 8'h00);
    end
    $display("reset test done");
  endtask
  // Reserved bits must clear again on a reset in mid-run
  task automatic testMidReset;
    rd(8'h76, 8'hf8);
    @(posedge sysClk);
    rstn <= 1'b0;
    @(negedge sysClk);
    check(regRdData, asm_pkg::ASM_UNMAPPED_DATA);
    @(posedge sysClk);
    rstn <= 1'b1;
    rd(8'h76, 8'h88);
    $display("mid reset test done");
  endtask
  task automatic testOffset;
    @(posedge sysClk);
    st.rightDiffOffsetSign <= 1'b1;
    st.rightCommonFbOffsetCode <= 5'h1f;
    st.rightDiffOffsetMagnitude <= 8'ha5;
    rd(8'h71, 8'h9f);
    wr(8'h71, 8'h00);
    wr(8'h6f, 8'h00);
    rd(8'h6f, 8'ha5);
    wr(8'h71, 8'h7f);
    st.rightDiffOffsetSign <= 1'b0;
    st.rightCommonFbOffsetCode <= 5'h01;
    rd(8'h71, 8'h61);
    $display("offset test done");
  endtask
  task automatic testMute;
    logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
    wr(8'h72, 8'hff);
    for (int i = 0; i < 4; i++) begin
      @(posedge sysClk);
      {st.muteAboveHigh, st.muteAboveLow} <= i[1:0];
      rd(8'h72, {6'h3f, exp[i]});
    end
    $display("mute test done");
  endtask
  task automatic testRate;
    for (int i = 0; i < 16; i++) begin
      @(posedge sysClk);
      st.autoConfigActive <= i[3];
      st.autoRateMode <= i[2:0];
      st.swRateMode <= ~i[2:0];
      rd(8'h73, {5'h00, i[3] ? i[2:0] : ~i[2:0]});
    end
    $display("rate test done");
  endtask
  task automatic testBootPins;
    for (int i = 0; i < 18; i++) begin
      @(posedge sysClk);
      st.bootDone <= i[0];
      st.outputPowerState <= 4'(i / 2);
      rd(8'h76, {i[0], 3'h0, 4'(i / 2)});
    end
    wr(8'h76, 8'h7f);
    rd(8'h76, 8'hf8);
    for (int i = 0; i < 8; i++) begin
      @(posedge sysClk);
      {st.gpPin2Level, st.threeLevelMutePin, st.gpPin0Level} <= i[2:0];
      rd(8'h77, {2'h0, i[2:0], 3'h0});
    end
    wr(8'h77, 8'hff);
    rd(8'h77, 8'hf8);
    wr(8'h74, 8'hff);
    rd(8'h74, 8'h00);
    $display("boot and pin test done");
  endtask
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {rstn, req, st, nMismatch, totalChecks, cycles} = '0;
    repeat (8) @(posedge sysClk);
    rstn <= 1'b1;
    @(posedge sysClk);
    testReset();
    testOffset();
    testMute();
    testRate();
    testBootPins();
    testMidReset();
    giveVerdict();
  end
endmodule
